// ---- logic/srcl_top.sv ----
// Sync ROM configuration register, latency timer and mode-register-set issue
`timescale 1ns/1ns
`default_nettype none
`include "srcl_params.svh"
// How it works
// - Reset clears bank 0 ROM enable; the first enabled edge after it loads the synchronised boot select pin.
// - RAS latency bit 0 gives one bus clock, 1 gives two.
// - Half rate clock doubles activate-to-read delay in internal cycles.
// - Reset forces RAS latency bit to one.
// - Bits 17 and 16 enable banks 3 and 2 as sync ROM.
// - Row bits field accepts only code 100; other codes are refused.
// - CAS latency codes 001 to 101 give two to six cycles.
// - Half rate clock doubles read-to-capture delay in internal cycles.
// - Every config write issues a mode register set, even unchanged.
// - Mode register set programs burst length eight.
module srcl_top import srcl_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic mem_clk_in,
	input wire logic boot_rom_select_pin_in,
	input wire logic half_rate_rom_clock_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic act_in,
	output logic read_cmd_out,
	output logic capture_out,
	output logic mrs_out,
	output logic [6:0] mrs_mode_out,
	output logic [3:0] rom_bank_en_out
);
	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	srcl_cfg_t cfg_ff;
	logic [31:0] prdata_ff;
	logic mrs_tgl_ff;
	logic mrs_ack_s1_ff, mrs_ack_s2_ff;
	logic boot_s1_ff, boot_s2_ff;
	logic rst_seen_ff;
	logic wr_cfg, acc;

	function automatic logic [31:0] cfg_word(input srcl_cfg_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`SRCL_BIT_SM0] = c.bank0_rom_enable;
		w[`SRCL_BIT_RL0] = c.ras_latency_pair01;
		w[`SRCL_BIT_SM3:`SRCL_BIT_SM2] = c.rom_enable_banks_hi;
		w[`SRCL_RA2_HI:`SRCL_RA2_LO] = c.row_bits_pair23;
		w[`SRCL_CL2_HI:`SRCL_CL2_LO] = c.cas_latency_pair23;
		return w;
	endfunction

	assign acc = psel_in && penable_in;
	assign wr_cfg = acc && pwrite_in && (paddr_in == `SRCL_ADDR_CFG);
	assign pready_out = 1'b1;
	assign pslverr_out = acc && (paddr_in != `SRCL_ADDR_CFG) && (paddr_in != `SRCL_ADDR_STAT);

	always_ff @(posedge sys_clk_in) begin
		// No reset here: the strap must already be settled when reset lifts
		if (clk_en_in) begin
			boot_s1_ff <= boot_rom_select_pin_in;
			boot_s2_ff <= boot_s1_ff;
		end
	end

	// Strap is caught on the first enabled edge after release, not under reset
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			cfg_ff.bank0_rom_enable <= 1'b0;
			cfg_ff.ras_latency_pair01 <= 1'b1;
			cfg_ff.rom_enable_banks_hi <= 2'h0;
			cfg_ff.row_bits_pair23 <= `SRCL_RA2_ONLY;
			cfg_ff.cas_latency_pair23 <= `SRCL_CL2_RST;
			rst_seen_ff <= 1'b1;
		end else if (clk_en_in) begin
			rst_seen_ff <= 1'b0;
			if (rst_seen_ff) begin
				cfg_ff.bank0_rom_enable <= boot_s2_ff;
			end else if (wr_cfg) begin
				cfg_ff.bank0_rom_enable <= pwdata_in[`SRCL_BIT_SM0];
			end
			if (wr_cfg) begin
				cfg_ff.ras_latency_pair01 <= pwdata_in[`SRCL_BIT_RL0];
				cfg_ff.rom_enable_banks_hi <= pwdata_in[`SRCL_BIT_SM3:`SRCL_BIT_SM2];
				// Reserved codes would mis-time fetches, so they are dropped
				if (pwdata_in[`SRCL_RA2_HI:`SRCL_RA2_LO] == `SRCL_RA2_ONLY) begin
					cfg_ff.row_bits_pair23 <= `SRCL_RA2_ONLY;
				end
				if (pwdata_in[`SRCL_CL2_HI:`SRCL_CL2_LO] >= `SRCL_CL2_MIN &&
					pwdata_in[`SRCL_CL2_HI:`SRCL_CL2_LO] <= `SRCL_CL2_MAX) begin
					cfg_ff.cas_latency_pair23 <= pwdata_in[`SRCL_CL2_HI:`SRCL_CL2_LO];
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			prdata_ff <= 32'h0000_0000;
		end else if (clk_en_in) begin
			if (psel_in && !penable_in && !pwrite_in) begin
				unique case (paddr_in)
					`SRCL_ADDR_CFG: prdata_ff <= cfg_word(cfg_ff);
					`SRCL_ADDR_STAT: prdata_ff <= {31'h0000_0000, mrs_tgl_ff ^ mrs_ack_s2_ff};
					default: prdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign prdata_out = prdata_ff;
	assign rom_bank_en_out = {cfg_ff.rom_enable_banks_hi, 1'b0, cfg_ff.bank0_rom_enable};

	// Unchanged writes still toggle, so the ROM always gets a fresh MRS
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			mrs_tgl_ff <= 1'b0;
		end else if (clk_en_in && wr_cfg) begin
			mrs_tgl_ff <= ~mrs_tgl_ff;
		end
	end

	// ----------------------------------------------------------------
	// Memory clock domain
	// ----------------------------------------------------------------
	logic m_rst_s1_ff, m_rst_ff;
	logic m_tgl_s1_ff, m_tgl_s2_ff, m_tgl_d_ff;
	logic mrs_ff;
	logic [6:0] mrs_mode_ff;
	logic m_ras_ff, m_half_s1_ff, m_half_ff;
	logic [2:0] m_cas_ff;
	logic [`SRCL_CNT_W-1:0] cnt_ff;
	logic read_ff, cap_ff;
	typedef enum logic [1:0] {SRCL_IDLE, SRCL_RCD, SRCL_CAS} srcl_st_t;
	srcl_st_t st_ff;

	always_ff @(posedge mem_clk_in) begin
		m_rst_s1_ff <= reset_in;
		m_rst_ff <= m_rst_s1_ff;
	end

	always_ff @(posedge mem_clk_in) begin
		if (m_rst_ff) begin
			m_tgl_s1_ff <= 1'b0;
			m_tgl_s2_ff <= 1'b0;
			m_tgl_d_ff <= 1'b0;
			m_half_s1_ff <= 1'b0;
			m_half_ff <= 1'b0;
		end else begin
			m_tgl_s1_ff <= mrs_tgl_ff;
			m_tgl_s2_ff <= m_tgl_s1_ff;
			m_tgl_d_ff <= m_tgl_s2_ff;
			m_half_s1_ff <= half_rate_rom_clock_in;
			m_half_ff <= m_half_s1_ff;
		end
	end

	// Config is static while the toggle settles, so sampling it here is safe
	always_ff @(posedge mem_clk_in) begin
		if (m_rst_ff) begin
			mrs_ff <= 1'b0;
			mrs_mode_ff <= 7'h00;
			m_ras_ff <= 1'b1;
			m_cas_ff <= `SRCL_CL2_RST;
		end else begin
			mrs_ff <= m_tgl_s2_ff ^ m_tgl_d_ff;
			if (m_tgl_s2_ff ^ m_tgl_d_ff) begin
				m_ras_ff <= cfg_ff.ras_latency_pair01;
				m_cas_ff <= cfg_ff.cas_latency_pair23;
				mrs_mode_ff <= {`SRCL_BURST8, cfg_ff.cas_latency_pair23,
					cfg_ff.ras_latency_pair01};
			end
		end
	end
	assign mrs_out = mrs_ff;
	assign mrs_mode_out = mrs_mode_ff;

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			mrs_ack_s1_ff <= 1'b0;
			mrs_ack_s2_ff <= 1'b0;
		end else if (clk_en_in) begin
			mrs_ack_s1_ff <= m_tgl_d_ff;
			mrs_ack_s2_ff <= mrs_ack_s1_ff;
		end
	end

	function automatic logic [`SRCL_CNT_W-1:0] scale(input logic [3:0] n, input logic h);
		return h ? {n[2:0], 1'b0} : n;
	endfunction

	logic [3:0] rcd_cyc, cas_cyc;
	assign rcd_cyc = {3'h0, m_ras_ff} + 4'h1;
	assign cas_cyc = {1'b0, m_cas_ff} + `SRCL_CL_OFS;

	always_ff @(posedge mem_clk_in) begin
		if (m_rst_ff) begin
			st_ff <= SRCL_IDLE;
			cnt_ff <= '0;
			read_ff <= 1'b0;
			cap_ff <= 1'b0;
		end else begin
			read_ff <= 1'b0;
			cap_ff <= 1'b0;
			unique case (st_ff)
				SRCL_IDLE: begin
					if (act_in) begin
						cnt_ff <= scale(rcd_cyc, m_half_ff);
						st_ff <= SRCL_RCD;
					end
				end
				SRCL_RCD: begin
					if (cnt_ff == 4'h1) begin
						read_ff <= 1'b1;
						cnt_ff <= scale(cas_cyc, m_half_ff);
						st_ff <= SRCL_CAS;
					end else begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				SRCL_CAS: begin
					if (cnt_ff == 4'h1) begin
						cap_ff <= 1'b1;
						st_ff <= SRCL_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
			endcase
		end
	end
	assign read_cmd_out = read_ff;
	assign capture_out = cap_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_strap;
		@(posedge sys_clk_in) disable iff (reset_in)
		(rst_seen_ff && clk_en_in) |=> (cfg_ff.bank0_rom_enable == $past(boot_s2_ff));
	endproperty
	a_strap: assert property (p_strap) else $error("bank0 enable not from strap");
	property p_rl_reset;
		@(posedge sys_clk_in) $fell(reset_in) |-> cfg_ff.ras_latency_pair01;
	endproperty
	a_rl_reset: assert property (p_rl_reset) else $error("ras latency not one after reset");
	property p_rl_wr;
		@(posedge sys_clk_in) disable iff (reset_in)
		(wr_cfg && clk_en_in) |=> (cfg_ff.ras_latency_pair01 == $past(pwdata_in[`SRCL_BIT_RL0]));
	endproperty
	a_rl_wr: assert property (p_rl_wr) else $error("ras latency write lost");
	property p_rom_enable_banks_hi;
		@(posedge sys_clk_in) disable iff (reset_in)
		(wr_cfg && clk_en_in) |=>
			(rom_bank_en_out[3:2] == $past(pwdata_in[`SRCL_BIT_SM3:`SRCL_BIT_SM2]));
	endproperty
	a_rom_enable_banks_hi: assert property (p_rom_enable_banks_hi) else $error("bank 2/3 enable wrong");
	property p_ra2;
		@(posedge sys_clk_in) disable iff (reset_in)
		cfg_ff.row_bits_pair23 == `SRCL_RA2_ONLY;
	endproperty
	a_ra2: assert property (p_ra2) else $error("row bits reserved code");
	property p_cl2;
		@(posedge sys_clk_in) disable iff (reset_in)
		cfg_ff.cas_latency_pair23 inside {[`SRCL_CL2_MIN:`SRCL_CL2_MAX]};
	endproperty
	a_cl2: assert property (p_cl2) else $error("cas latency reserved code");
	property p_mrs;
		@(posedge sys_clk_in) disable iff (reset_in)
		(wr_cfg && clk_en_in) |=> (mrs_tgl_ff != $past(mrs_tgl_ff));
	endproperty
	a_mrs: assert property (p_mrs) else $error("write did not request mrs");
	property p_bl8;
		@(posedge mem_clk_in) disable iff (m_rst_ff)
		mrs_ff |-> (mrs_mode_ff[6:4] == `SRCL_BURST8);
	endproperty
	a_bl8: assert property (p_bl8) else $error("mrs burst not eight");
	property p_rcd;
		@(posedge mem_clk_in) disable iff (m_rst_ff)
		(st_ff == SRCL_IDLE && act_in && !m_half_ff && !m_ras_ff) |=> !read_ff ##1 read_ff;
	endproperty
	a_rcd: assert property (p_rcd) else $error("one-cycle ras delay wrong");
	property p_rcd_half;
		@(posedge mem_clk_in) disable iff (m_rst_ff)
		(st_ff == SRCL_IDLE && act_in && m_half_ff && m_ras_ff) |=> !read_ff[*4] ##1 read_ff;
	endproperty
	a_rcd_half: assert property (p_rcd_half) else $error("half rate ras delay wrong");
	property p_cas_half;
		@(posedge mem_clk_in) disable iff (m_rst_ff)
		(read_ff && m_half_ff && m_cas_ff == 3'h1) |-> !cap_ff[*4] ##1 cap_ff;
	endproperty
	a_cas_half: assert property (p_cas_half) else $error("half rate cas delay wrong");
	c_wr: cover property (@(posedge sys_clk_in) wr_cfg && clk_en_in);
	c_mrs: cover property (@(posedge mem_clk_in) mrs_ff);
	c_cap: cover property (@(posedge mem_clk_in) cap_ff && m_half_ff);
endmodule
`default_nettype wire

// ---- common/srcl_params.svh ----
// Constants for the sync ROM configuration and latency block
`ifndef SRCL_PARAMS_SVH
`define SRCL_PARAMS_SVH
`define SRCL_ADDR_CFG 12'h030
`define SRCL_ADDR_CTRL 12'h034
`define SRCL_ADDR_STAT 12'h038
`define SRCL_BIT_SM0 0
`define SRCL_BIT_RL0 15
`define SRCL_BIT_SM2 16
`define SRCL_BIT_SM3 17
`define SRCL_RA2_LO 20
`define SRCL_RA2_HI 22
`define SRCL_CL2_LO 28
`define SRCL_CL2_HI 30
`define SRCL_RA2_ONLY 3'h4
`define SRCL_CL2_MIN 3'h1
`define SRCL_CL2_MAX 3'h5
`define SRCL_CL2_RST 3'h1
`define SRCL_CL_OFS 4'h1
`define SRCL_BURST8 3'h3
`define SRCL_CNT_W 4
`endif

// ---- common/srcl_pkg.sv ----
// Types for the sync ROM configuration and latency block
package srcl_pkg;
	typedef struct packed {
		logic [2:0] cas_latency_pair23;
		logic [2:0] row_bits_pair23;
		logic [1:0] rom_enable_banks_hi;
		logic ras_latency_pair01;
		logic bank0_rom_enable;
	} srcl_cfg_t;
	typedef struct packed {
		logic [2:0] burst_len;
		logic [2:0] cas_lat;
		logic ras_lat;
	} srcl_mrs_t;
endpackage

// ---- verification/srcl_rom_model.sv ----
// Behavioural model of the sync ROM devices' mode register
`timescale 1ns/1ns
`default_nettype none
module srcl_rom_model import srcl_pkg::*; (
	input wire logic mem_clk_in,
	input wire logic mrs_in,
	input wire srcl_mrs_t mrs_mode_in,
	output srcl_mrs_t mode_out,
	output logic loaded_out
);
	initial begin
		mode_out = '0;
		loaded_out = 1'b0;
	end
	// Takes any code, as real parts do; the bench judges the value
	always @(posedge mem_clk_in) begin
		loaded_out <= (mrs_in === 1'b1);
		if (mrs_in === 1'b1) begin
			mode_out <= mrs_mode_in;
		end
	end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the sync ROM configuration block
`timescale 1ns/1ns
`default_nettype none
`include "srcl_params.svh"
module tb import srcl_pkg::*;;
	logic clk = 0, mclk = 0, rst = 1, boot = 1, half = 0, act = 0;
	logic psel = 0, pen = 0, pwr = 0, rdy, serr, rdc, cap, mrs, seen;
	logic [11:0] pa = '0;
	logic [31:0] pwd = '0, prd, r, ecfg, d;
	logic [6:0] mode;
	logic [3:0] ben;
	logic serr_s;
	srcl_mrs_t seen_mode;
	srcl_mrs_t exp_q[$];
	int bad_count = 0, comparisons = 0;
	initial forever #20 clk = ~clk;
	// Offset start keeps the memory clock unrelated in phase
	initial begin
		#7;
		forever #3 mclk = ~mclk;
	end
	srcl_top dut(.sys_clk_in(clk), .reset_in(rst), .clk_en_in(1'b1), .mem_clk_in(mclk),
		.boot_rom_select_pin_in(boot), .half_rate_rom_clock_in(half), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
		.prdata_out(prd), .pready_out(rdy), .pslverr_out(serr), .act_in(act),
		.read_cmd_out(rdc), .capture_out(cap), .mrs_out(mrs), .mrs_mode_out(mode),
		.rom_bank_en_out(ben));
	srcl_rom_model rom(.mem_clk_in(mclk), .mrs_in(mrs), .mrs_mode_in(mode),
		.mode_out(seen_mode), .loaded_out(seen));
	// ----------------------------------------
	// Checking and verdict
	// ----------------------------------------
	task give_verdict();
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Each mode register load must match the oldest note
	always @(posedge mclk) begin
		if (seen === 1'b1) begin
			if (exp_q.size() == 0)
				check(32'(seen_mode), 32'hFFFF_FFFF);
			else
				check(32'(seen_mode), 32'(exp_q.pop_front()));
		end
	end
	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= dat;
		@(posedge clk) pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			give_verdict();
		end
		r = prd;
		serr_s = serr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	// Reserved codes keep the old field, yet every write still sends a mode set
	task automatic wcfg(input logic [31:0] dat);
		if (dat[30:28] inside {[`SRCL_CL2_MIN:`SRCL_CL2_MAX]})
			ecfg[30:28] = dat[30:28];
		ecfg[17:15] = dat[17:15];
		ecfg[0] = dat[0];
		exp_q.push_back({`SRCL_BURST8, ecfg[30:28], ecfg[15]});
		apb(1'b1, `SRCL_ADDR_CFG, dat);
	endtask
	task automatic rcfg();
		apb(1'b0, `SRCL_ADDR_CFG, '0);
		check(r, ecfg);
		check(ben, {ecfg[17:16], 1'b0, ecfg[0]});
	endtask
	task automatic do_reset(input logic b);
		boot <= b;
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		ecfg = 32'h1040_8000 | 32'(b);
	endtask
	task automatic lat(input int n_exp, input int m_exp);
		int n, m;
		@(posedge mclk) act <= 1'b1;
		@(posedge mclk) act <= 1'b0;
		n = 0;
		m = 0;
		do begin
			@(posedge mclk) #1;
			n++;
		end while (rdc !== 1'b1 && n < 40);
		do begin
			@(posedge mclk) #1;
			m++;
		end while (cap !== 1'b1 && m < 40);
		check(n, n_exp);
		check(m, m_exp);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'hE38F));
		do_reset(1'b1);
		rcfg();
		wcfg(ecfg); // Present value forces a burst-eight mode set
		rcfg();
		repeat (3) @(posedge clk);
		// Strap low first, so the RAS bit may be moved safely
		do_reset(1'b0);
		rcfg();
		for (int c = 0; c < 8; c++) begin
			d = $urandom();
			d[30:28] = 3'(c);
			d[22:20] = 3'(7 - c);
			wcfg(d);
			rcfg();
		end
		apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
		check(serr_s, 1'b1);
		rcfg();
		for (int h = 0; h < 2; h++) begin
			half <= h[0];
			for (int ra = 0; ra < 2; ra++) begin
				for (int c = 1; c < 6; c++) begin
					d = ecfg;
					d[15] = ra[0];
					d[30:28] = 3'(c);
					wcfg(d);
					// No ROM read until the mode set has landed
					repeat (2) @(posedge clk);
					lat((ra + 1) * (h + 1), (c + 1) * (h + 1));
					@(posedge clk);
				end
			end
		end
		repeat (4) @(posedge clk);
		apb(1'b0, `SRCL_ADDR_STAT, '0);
		check(r, 32'h0000_0000);
		check(exp_q.size(), 0);
		give_verdict();
	end
	initial begin
		#3000000;
		bad_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
